//--- adcctl_top.sv
// Converter channel decode, conversion clock, trigger and SAR sequencing
//
// Design decisions made here: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "adcctl_defs.svh"

module adcctl_top import adcctl_pkg::*; #(
   parameter int unsigned KHZ_DIV = `ADCCTL_KHZ_DIV
) (
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   input wire adcctl_pwr_e power_mode_i,
   input wire logic clock_source_ext_ref_clock_i,
   input wire logic local_async_conv_clock_i,
   input wire logic sar_comp_i,
   output logic [9:0] sar_dac_o,
   output logic sar_sample_o,
   output logic sar_power_o,
   output adcctl_mux_s mux_sel_o,
   output logic bandgap_buffer_enable_o,
   output logic conv_irq_o
);

   // ==========================================================
   // Registers
   logic coco_reg;
   logic aien_reg;
   logic cont_reg;
   logic [4:0] conv_channel_select_reg;
   logic hwt_en_reg;
   logic cmp_en_reg;
   logic cmp_ge_reg;
   logic [9:0] result_reg;
   logic [9:0] cmp_val_reg;
   logic mode10_reg;
   adcctl_clk_e clk_sel_reg;
   logic [7:0] analog_pin_enable_reg1;
   logic prd_ext_reg;
   logic [2:0] prd_rate_reg;
   logic [2:0] pwr_reg;
   adcctl_state_e state_reg;
   adcctl_state_e state_next;
   logic [9:0] dac_reg;
   logic [9:0] mask_reg;
   logic div2_reg;
   logic async_prev_reg;

   // ==========================================================
   // Bus decode
   logic sel_sc1, sel_sc2, sel_resh, sel_resl, sel_cvh, sel_cvl, sel_cfg, sel_pin, sel_prd, sel_pwr;
   logic sc1_wr;
   logic resl_rd;
   logic [7:0] rdata_next;

   assign sel_sc1 = (reg_addr_i == `ADCCTL_A_SC1);
   assign sel_sc2 = (reg_addr_i == `ADCCTL_A_SC2);
   assign sel_resh = (reg_addr_i == `ADCCTL_A_RESH);
   assign sel_resl = (reg_addr_i == `ADCCTL_A_RESL);
   assign sel_cvh = (reg_addr_i == `ADCCTL_A_CVH);
   assign sel_cvl = (reg_addr_i == `ADCCTL_A_CVL);
   assign sel_cfg = (reg_addr_i == `ADCCTL_A_CFG);
   assign sel_pin = (reg_addr_i == `ADCCTL_A_PINEN);
   assign sel_prd = (reg_addr_i == `ADCCTL_A_PRD);
   assign sel_pwr = (reg_addr_i == `ADCCTL_A_PWR);
   assign sc1_wr = reg_wr_i & sel_sc1;
   assign resl_rd = reg_rd_i & sel_resl;

   // ==========================================================
   // Channel decode
   function automatic adcctl_mux_s decode_ch(input logic [4:0] ch, input logic [7:0] pin_en);
      adcctl_mux_s m;
      m = '0;
      if (ch <= `ADCCTL_CH_PIN_LAST) begin
         m.pin = pin_en & (8'h01 << ch[2:0]);
      end else if (ch >= `ADCCTL_CH_GND_FIRST && ch <= `ADCCTL_CH_GND_LAST) begin
         m.gnd = 1'b1;
      end else if (ch == `ADCCTL_CH_TEMP) begin
         m.temp = 1'b1;
      end else if (ch == `ADCCTL_CH_BGAP) begin
         m.bandgap = 1'b1;
      end else if (ch == `ADCCTL_CH_VREFH) begin
         m.vrefh = 1'b1;
      end else if (ch == `ADCCTL_CH_VREFL) begin
         m.vrefl = 1'b1;
      end else if (ch != `ADCCTL_CH_OFF) begin
         // Nothing is attached; the result is whatever the array settles to
         m.reserved = 1'b1;
      end
      return m;
   endfunction : decode_ch

   // ==========================================================
   // Conversion clock and run conditions
   logic conv_tick;
   logic run_ok;
   logic prd_run;
   logic ch_off;
   logic new_ch_off;
   logic prd_trig;
   logic hw_conv_trigger;
   logic can_start;

   always_comb begin
      case (clk_sel_reg)
         ADCCTL_CLK_BUS: conv_tick = 1'b1;
         ADCCTL_CLK_BUS_DIV2: conv_tick = div2_reg;
         ADCCTL_CLK_ASYNC: conv_tick = local_async_conv_clock_i & ~async_prev_reg;
         default: conv_tick = 1'b0;
      endcase
   end

   // Stop3 keeps converting only with both detector enables set
   assign run_ok = (power_mode_i == ADCCTL_PWR_RUN) | (power_mode_i == ADCCTL_PWR_WAIT) |
                   ((power_mode_i == ADCCTL_PWR_STOP3) & pwr_reg[`ADCCTL_PWR_LOW_VOLT_DETECT_ENABLE] &
                    pwr_reg[`ADCCTL_PWR_LOW_VOLT_DETECT_STOP_ENABLE]);
   assign prd_run = (power_mode_i != ADCCTL_PWR_STOP12);
   assign ch_off = (conv_channel_select_reg == `ADCCTL_CH_OFF);
   assign new_ch_off = (reg_wdata_i[4:0] == `ADCCTL_CH_OFF);
   assign hw_conv_trigger = hwt_en_reg & prd_trig;
   assign can_start = run_ok & ~ch_off;

   adcctl_prd_cnt #(
      .KHZ_DIV(KHZ_DIV)
   ) u_prd_cnt (
      .ref_clk_i(ref_clk_i),
      .sys_rst_i(sys_rst_i),
      .ext_src_i(prd_ext_reg),
      .rate_sel_i(prd_rate_reg),
      .run_en_i(prd_run),
      .clock_source_ext_ref_clock_i(clock_source_ext_ref_clock_i),
      .overflow_o(prd_trig)
   );

   // ==========================================================
   // Result formatting and compare
   logic [9:0] sar_keep;
   logic [9:0] res_fmt;
   logic [9:0] cv_fmt;
   logic cmp_true;
   logic done_flag;
   logic [9:0] dac_next;

   assign sar_keep = sar_comp_i ? dac_reg : (dac_reg ^ mask_reg);
   assign res_fmt = mode10_reg ? result_reg : {2'h0, result_reg[9:2]};
   assign cv_fmt = mode10_reg ? cmp_val_reg : {2'h0, cmp_val_reg[7:0]};
   assign cmp_true = cmp_ge_reg ? (res_fmt >= cv_fmt) : (res_fmt < cv_fmt);
   assign done_flag = (state_reg == ADCCTL_ST_DONE) & (~cmp_en_reg | cmp_true);
   // Array and keep decision must see the same trial code, so the pad is loaded with the next value
   assign dac_next = (state_next == ADCCTL_ST_SAMPLE) ? `ADCCTL_SAR_MSB :
                     ((state_reg == ADCCTL_ST_CONVERT && conv_tick) ? (sar_keep | (mask_reg >> 1)) : dac_reg);

   // ==========================================================
   // Sequencer
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ADCCTL_ST_IDLE: begin
            if (can_start & hw_conv_trigger) begin
               state_next = ADCCTL_ST_SAMPLE;
            end
         end
         ADCCTL_ST_SAMPLE: begin
            if (conv_tick) begin
               state_next = ADCCTL_ST_CONVERT;
            end
         end
         ADCCTL_ST_CONVERT: begin
            if (conv_tick && mask_reg == `ADCCTL_SAR_LSB) begin
               state_next = ADCCTL_ST_DONE;
            end
         end
         ADCCTL_ST_DONE: begin
            if (can_start & (cont_reg | hw_conv_trigger)) begin
               state_next = ADCCTL_ST_SAMPLE;
            end else begin
               state_next = ADCCTL_ST_IDLE;
            end
         end
         default: state_next = ADCCTL_ST_IDLE;
      endcase
      if (sc1_wr) begin
         // Abort; software trigger restarts at once, hardware waits for overflow
         state_next = (~new_ch_off & ~hwt_en_reg & run_ok) ? ADCCTL_ST_SAMPLE : ADCCTL_ST_IDLE;
      end else if (ch_off | ~run_ok) begin
         state_next = ADCCTL_ST_IDLE;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         state_reg <= ADCCTL_ST_IDLE;
         dac_reg <= '0;
         mask_reg <= '0;
         div2_reg <= 1'b0;
         async_prev_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         div2_reg <= ~div2_reg;
         async_prev_reg <= local_async_conv_clock_i;
         dac_reg <= dac_next;
         if (state_next == ADCCTL_ST_SAMPLE) begin
            mask_reg <= `ADCCTL_SAR_MSB;
         end else if (state_reg == ADCCTL_ST_CONVERT && conv_tick) begin
            mask_reg <= mask_reg >> 1;
         end
      end
   end

   // ==========================================================
   // Software registers
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         aien_reg <= 1'b0;
         cont_reg <= 1'b0;
         conv_channel_select_reg <= `ADCCTL_CH_OFF;
         hwt_en_reg <= 1'b0;
         cmp_en_reg <= 1'b0;
         cmp_ge_reg <= 1'b0;
         cmp_val_reg <= '0;
         mode10_reg <= 1'b0;
         clk_sel_reg <= ADCCTL_CLK_BUS;
         analog_pin_enable_reg1 <= `ADCCTL_RST_BYTE;
         prd_ext_reg <= 1'b0;
         prd_rate_reg <= '0;
         pwr_reg <= '0;
      end else if (reg_wr_i) begin
         if (sel_sc1) begin
            aien_reg <= reg_wdata_i[`ADCCTL_SC1_AIEN];
            cont_reg <= reg_wdata_i[`ADCCTL_SC1_CONT];
            conv_channel_select_reg <= reg_wdata_i[4:0];
         end else if (sel_sc2) begin
            hwt_en_reg <= reg_wdata_i[`ADCCTL_SC2_HWT];
            cmp_en_reg <= reg_wdata_i[`ADCCTL_SC2_CMPEN];
            cmp_ge_reg <= reg_wdata_i[`ADCCTL_SC2_CMPGE];
         end else if (sel_cvh) begin
            cmp_val_reg[9:8] <= reg_wdata_i[1:0];
         end else if (sel_cvl) begin
            cmp_val_reg[7:0] <= reg_wdata_i;
         end else if (sel_cfg) begin
            mode10_reg <= reg_wdata_i[`ADCCTL_CFG_MODE10];
            clk_sel_reg <= adcctl_clk_e'(reg_wdata_i[1:0]);
         end else if (sel_pin) begin
            analog_pin_enable_reg1 <= reg_wdata_i;
         end else if (sel_prd) begin
            prd_ext_reg <= reg_wdata_i[`ADCCTL_PRD_EXTSRC];
            prd_rate_reg <= reg_wdata_i[2:0];
         end else if (sel_pwr) begin
            pwr_reg <= reg_wdata_i[2:0];
         end
      end
   end

   // Complete flag: a finishing conversion beats the result-low read clear
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         coco_reg <= 1'b0;
         result_reg <= '0;
      end else begin
         if (state_reg == ADCCTL_ST_CONVERT && state_next == ADCCTL_ST_DONE) begin
            result_reg <= sar_keep;
         end
         if (sc1_wr) begin
            coco_reg <= 1'b0;
         end else if (done_flag) begin
            coco_reg <= 1'b1;
         end else if (resl_rd) begin
            coco_reg <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Read port and outputs
   always_comb begin
      if (sel_sc1) begin
         rdata_next = {coco_reg, aien_reg, cont_reg, conv_channel_select_reg};
      end else if (sel_sc2) begin
         rdata_next = {state_reg != ADCCTL_ST_IDLE, hwt_en_reg, cmp_en_reg, cmp_ge_reg, 4'h0};
      end else if (sel_resh) begin
         rdata_next = {6'h00, res_fmt[9:8]};
      end else if (sel_resl) begin
         rdata_next = res_fmt[7:0];
      end else if (sel_cvh) begin
         rdata_next = {6'h00, cmp_val_reg[9:8]};
      end else if (sel_cvl) begin
         rdata_next = cmp_val_reg[7:0];
      end else if (sel_cfg) begin
         rdata_next = {5'h00, mode10_reg, clk_sel_reg};
      end else if (sel_pin) begin
         rdata_next = analog_pin_enable_reg1;
      end else if (sel_prd) begin
         rdata_next = {3'h0, prd_ext_reg, 1'b0, prd_rate_reg};
      end else if (sel_pwr) begin
         rdata_next = {5'h00, pwr_reg};
      end else begin
         rdata_next = `ADCCTL_RST_BYTE;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         reg_rdata_o <= `ADCCTL_RST_BYTE;
         mux_sel_o <= '0;
         sar_dac_o <= '0;
         sar_sample_o <= 1'b0;
         sar_power_o <= 1'b0;
         bandgap_buffer_enable_o <= 1'b0;
         conv_irq_o <= 1'b0;
      end else begin
         reg_rdata_o <= reg_rd_i ? rdata_next : `ADCCTL_RST_BYTE;
         mux_sel_o <= decode_ch(conv_channel_select_reg, analog_pin_enable_reg1);
         sar_dac_o <= dac_next;
         sar_sample_o <= (state_reg == ADCCTL_ST_SAMPLE);
         // Array powers down between single conversions to save current
         sar_power_o <= (state_reg != ADCCTL_ST_IDLE);
         bandgap_buffer_enable_o <= pwr_reg[`ADCCTL_PWR_BANDGAP_BUFFER_ENABLE];
         conv_irq_o <= coco_reg & aien_reg;
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (sys_rst_i);

   property p_off_idle;
      ch_off && !sc1_wr |=> state_reg == ADCCTL_ST_IDLE;
   endproperty
   a_off_idle: assert property (p_off_idle) else $error("Converter ran with channel off");

   property p_wr_restart;
      sc1_wr && !new_ch_off && !hwt_en_reg && run_ok |=> state_reg == ADCCTL_ST_SAMPLE ##1 sar_sample_o;
   endproperty
   a_wr_restart: assert property (p_wr_restart) else $error("Control write did not restart");

   property p_done_flag;
      state_reg == ADCCTL_ST_DONE && !cmp_en_reg && !sc1_wr |=> coco_reg ##1 (conv_irq_o == aien_reg);
   endproperty
   a_done_flag: assert property (p_done_flag) else $error("Complete flag or irq missing");

   property p_fmt8;
      !mode10_reg |-> res_fmt[9:8] == 2'h0 && res_fmt[7:0] == result_reg[9:2];
   endproperty
   a_fmt8: assert property (p_fmt8) else $error("8-bit result not right-justified");

   property p_single_idle;
      state_reg == ADCCTL_ST_DONE && !cont_reg && !hw_conv_trigger && !sc1_wr |=> state_reg == ADCCTL_ST_IDLE;
   endproperty
   a_single_idle: assert property (p_single_idle) else $error("Single conversion did not idle");

   property p_trig_pulse;
      prd_trig |=> !prd_trig;
   endproperty
   a_trig_pulse: assert property (p_trig_pulse) else $error("Trigger longer than one cycle");

   property p_alt_dead;
      clk_sel_reg == ADCCTL_CLK_ALT && state_reg == ADCCTL_ST_SAMPLE && !sc1_wr |=> state_reg != ADCCTL_ST_CONVERT;
   endproperty
   a_alt_dead: assert property (p_alt_dead) else $error("Alternate clock produced ticks");

   property p_vrefh;
      conv_channel_select_reg == `ADCCTL_CH_VREFH |=> mux_sel_o.vrefh && mux_sel_o.pin == 8'h00;
   endproperty
   a_vrefh: assert property (p_vrefh) else $error("High reference not selected");

   property p_hw_start;
      state_reg == ADCCTL_ST_IDLE && hw_conv_trigger && can_start && !sc1_wr |=> state_reg == ADCCTL_ST_SAMPLE;
   endproperty
   a_hw_start: assert property (p_hw_start) else $error("Overflow did not start conversion");

   property p_cmp_flag;
      state_reg == ADCCTL_ST_DONE && cmp_en_reg && !cmp_true && !sc1_wr && !coco_reg |=> !coco_reg;
   endproperty
   a_cmp_flag: assert property (p_cmp_flag) else $error("Flag set on false compare");

endmodule : adcctl_top

`default_nettype wire

//--- adcctl_defs.svh
// Constants for the converter channel, clock and trigger control block
// How it works
// - Channel codes 0-7 route enabled pins, 8-21 ground, 29/30 references, 31 off.
// - Reserved channel codes give an unspecified result; expect no value.
// - Conversions run from bus clock, bus clock halved, or local async clock.
// - The alternate conversion clock is unconnected, so selecting it gives no clock.
// - With hardware trigger on, a periodic counter overflow starts a conversion unless one is running.
// - Periodic counter counts external reference clock or a nominal 1 kHz clock.
// - Periodic counter free-runs; overflow period set by rate select and input clock.
// - Periodic triggers work in run and wait, and in the third stop mode only with both detector enables set.
// - Only one analog pin enable register, the first bank, exists.
// - Results come from a binary 10-bit successive-approximation search.
// - Results are right-justified, 10-bit or 8-bit as the format selects.
// - Single or continuous conversion; a single conversion returns to idle.
// - Optional compare flags results less-than or greater-or-equal to a set value.
// - Conversion complete flag is set at the end and can raise an interrupt.
// - Channel code 11010 selects the on-chip temperature sensor.
// - Writing status/control 1 aborts; with software trigger it restarts, unless channel is all ones.
// - Channel all ones turns the converter off; continuous mode stops at once.
`ifndef ADCCTL_DEFS_SVH
`define ADCCTL_DEFS_SVH

// ==========================================================
// Register map
`define ADCCTL_A_SC1 8'h00
`define ADCCTL_A_SC2 8'h01
`define ADCCTL_A_RESH 8'h02
`define ADCCTL_A_RESL 8'h03
`define ADCCTL_A_CVH 8'h04
`define ADCCTL_A_CVL 8'h05
`define ADCCTL_A_CFG 8'h06
`define ADCCTL_A_PINEN 8'h07
`define ADCCTL_A_PRD 8'h08
`define ADCCTL_A_PWR 8'h09

// ==========================================================
// Field positions and reset values
`define ADCCTL_SC1_COCO 7
`define ADCCTL_SC1_AIEN 6
`define ADCCTL_SC1_CONT 5
`define ADCCTL_SC2_ACT 7
`define ADCCTL_SC2_HWT 6
`define ADCCTL_SC2_CMPEN 5
`define ADCCTL_SC2_CMPGE 4
`define ADCCTL_CFG_MODE10 2
`define ADCCTL_PRD_EXTSRC 4
`define ADCCTL_PWR_BANDGAP_BUFFER_ENABLE 2
`define ADCCTL_PWR_LOW_VOLT_DETECT_ENABLE 1
`define ADCCTL_PWR_LOW_VOLT_DETECT_STOP_ENABLE 0
`define ADCCTL_CH_OFF 5'h1f
`define ADCCTL_CH_PIN_LAST 5'h07
`define ADCCTL_CH_GND_FIRST 5'h08
`define ADCCTL_CH_GND_LAST 5'h15
`define ADCCTL_CH_TEMP 5'h1a
`define ADCCTL_CH_BGAP 5'h1b
`define ADCCTL_CH_VREFH 5'h1d
`define ADCCTL_CH_VREFL 5'h1e
`define ADCCTL_RST_BYTE 8'h00
`define ADCCTL_SAR_MSB 10'h200
`define ADCCTL_SAR_LSB 10'h001
`define ADCCTL_PRD_BASE_LOG2 3

// ==========================================================
// Timing
`define ADCCTL_CLK_PERIOD_NS 5
`define ADCCTL_KHZ_PERIOD_NS 1000000
`define ADCCTL_KHZ_DIV (`ADCCTL_KHZ_PERIOD_NS / `ADCCTL_CLK_PERIOD_NS)

`endif

//--- adcctl_pkg.sv
// Types shared by the converter control block
`include "adcctl_defs.svh"

package adcctl_pkg;

   typedef enum logic [3:0] {
      ADCCTL_ST_IDLE = 4'b0001,
      ADCCTL_ST_SAMPLE = 4'b0010,
      ADCCTL_ST_CONVERT = 4'b0100,
      ADCCTL_ST_DONE = 4'b1000
   } adcctl_state_e;

   typedef enum logic [1:0] {
      ADCCTL_CLK_BUS = 2'h0,
      ADCCTL_CLK_BUS_DIV2 = 2'h1,
      ADCCTL_CLK_ALT = 2'h2,
      ADCCTL_CLK_ASYNC = 2'h3
   } adcctl_clk_e;

   typedef enum logic [1:0] {
      ADCCTL_PWR_RUN = 2'h0,
      ADCCTL_PWR_WAIT = 2'h1,
      ADCCTL_PWR_STOP3 = 2'h2,
      ADCCTL_PWR_STOP12 = 2'h3
   } adcctl_pwr_e;

   // Analog input mux controls
   typedef struct packed {
      logic [7:0] pin;
      logic gnd;
      logic vrefh;
      logic vrefl;
      logic temp;
      logic bandgap;
      logic reserved;
   } adcctl_mux_s;

endpackage : adcctl_pkg

//--- adcctl_prd_cnt.sv
// Free-running periodic counter that issues the hardware conversion trigger
`timescale 1ns/1ps
`default_nettype none

module adcctl_prd_cnt import adcctl_pkg::*; #(
   parameter int unsigned KHZ_DIV = `ADCCTL_KHZ_DIV
) (
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   input wire logic ext_src_i,
   input wire logic [2:0] rate_sel_i,
   input wire logic run_en_i,
   input wire logic clock_source_ext_ref_clock_i,
   output logic overflow_o
);

   logic [17:0] kdiv_reg;
   logic ext_prev_reg;
   logic [10:0] cnt_reg;
   logic khz_tick;
   logic ext_tick;
   logic tick;
   logic [10:0] limit;
   logic wrap;

   // ==========================================================
   // Tick sources
   assign khz_tick = (kdiv_reg == 18'(KHZ_DIV - 1));
   assign ext_tick = clock_source_ext_ref_clock_i & ~ext_prev_reg;
   assign tick = run_en_i & (rate_sel_i != 3'h0) & (ext_src_i ? ext_tick : khz_tick);
   // Period is 2^(rate+3) source ticks; rate 0 parks the counter
   // Shift amount is widened first so the slowest rate does not wrap past three bits
   assign limit = 11'((12'h001 << ({1'b0, rate_sel_i} + 4'(`ADCCTL_PRD_BASE_LOG2))) - 12'h001);
   assign wrap = tick & (cnt_reg == limit);

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         kdiv_reg <= '0;
         ext_prev_reg <= 1'b0;
         cnt_reg <= '0;
         overflow_o <= 1'b0;
      end else begin
         kdiv_reg <= khz_tick ? '0 : kdiv_reg + 18'h0_0001;
         ext_prev_reg <= clock_source_ext_ref_clock_i;
         cnt_reg <= wrap ? '0 : (tick ? cnt_reg + 11'h001 : cnt_reg);
         overflow_o <= wrap;
      end
   end

endmodule : adcctl_prd_cnt

`default_nettype wire

//--- adcctl_top_tb.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none

module adcctl_top_tb import adcctl_pkg::*; ;
   logic ref_clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   adcctl_pwr_e pwr_i = ADCCTL_PWR_RUN;
   logic ext_clk = 1'b0;
   logic async_clk = 1'b0;
   logic [9:0] target = 10'h000;
   logic [7:0] rdata;
   logic [9:0] dac;
   logic samp;
   logic pwr_o;
   logic bg;
   logic irq;
   adcctl_mux_s mux;
   // Analog comparator is a level, so it follows the trial code at once
   wire logic comp = (target >= dac);
   int err_total = 0;
   int checks = 0;
   int cyc = 0;
   logic [7:0] exp_q[$];
   logic rd_seen = 1'b0;

   adcctl_top #(.KHZ_DIV(8)) i_dut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(addr),
      .reg_wdata_i(wdata), .reg_wr_i(wr_i), .reg_rd_i(rd_i), .reg_rdata_o(rdata), .power_mode_i(pwr_i),
      .clock_source_ext_ref_clock_i(ext_clk), .local_async_conv_clock_i(async_clk), .sar_comp_i(comp),
      .sar_dac_o(dac), .sar_sample_o(samp), .sar_power_o(pwr_o), .mux_sel_o(mux),
      .bandgap_buffer_enable_o(bg), .conv_irq_o(irq));

   // ==========================================
   // Checking
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
      end
   endtask : chk

   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : end_sim

   always #2.5 ref_clk_i = ~ref_clk_i;

   // Read data stand only in the cycle after the strobe
   always @(posedge ref_clk_i) begin
      ext_clk <= ~ext_clk;
      async_clk <= cyc[1];
      cyc <= cyc + 1;
      rd_seen <= rd_i;
      if (rd_seen) chk(rdata, exp_q.pop_front());
      if (cyc > 20000) begin
         err_total++;
         end_sim();
      end
   end

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk_i);
      wr_i <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge ref_clk_i);
      wr_i <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      @(posedge ref_clk_i);
      rd_i <= 1'b1;
      addr <= a;
      @(posedge ref_clk_i);
      rd_i <= 1'b0;
   endtask : rd

   // Bounded wait, then the interrupt level is compared
   task automatic wait_irq(input int n, input logic e);
      // Let a clear from the starting write reach the registered irq first
      repeat (2) @(posedge ref_clk_i);
      for (int i = 0; i < n && irq !== 1'b1; i++) @(posedge ref_clk_i);
      chk(irq, e);
   endtask : wait_irq

   function automatic logic [5:0] mux_exp(input int c);
      return {c >= 8 && c <= 21, c == 29, c == 30, c == 26, c == 27, (c >= 22 && c <= 25) || c == 28};
   endfunction : mux_exp

   // ==========================================
   // Scenarios
   initial begin
      void'($urandom(75));
      repeat (3) @(posedge ref_clk_i);
      sys_rst_i <= 1'b0;
      rd(8'h00, 8'h1f);
      rd(8'h01, 8'h00);
      rd(8'h20, 8'h00);
      $display("reset values done");
      wr(8'h07, 8'hff);
      for (int c = 0; c < 32; c++) begin
         wr(8'h00, 8'(c));
         repeat (2) @(posedge ref_clk_i);
         chk(mux[5:0], mux_exp(c));
         chk(mux.pin, (c < 8) ? (8'h01 << c) : 8'h00);
      end
      $display("channel decode done");
      for (int k = 0; k < 5; k++) begin
         wr(8'h06, (k == 4) ? 8'h00 : 8'h04);
         target <= (k == 0) ? 10'h3ff : (k == 1) ? 10'h000 : 10'($urandom());
         wr(8'h00, 8'h40);
         wait_irq(40, 1'b1);
         rd(8'h02, (k == 4) ? 8'h00 : {6'h00, target[9:8]});
         rd(8'h03, (k == 4) ? target[9:2] : target[7:0]);
         rd(8'h00, 8'h40);
         chk(pwr_o, 1'b0);
      end
      $display("conversion done");
      wr(8'h06, 8'h04);
      wr(8'h04, 8'h02);
      wr(8'h05, 8'h00);
      wr(8'h01, 8'h30);
      target <= 10'h1ff;
      wr(8'h00, 8'h40);
      wait_irq(40, 1'b0);
      target <= 10'h200;
      wr(8'h00, 8'h40);
      wait_irq(40, 1'b1);
      wr(8'h01, 8'h20);
      target <= 10'h1ff;
      wr(8'h00, 8'h40);
      wait_irq(40, 1'b1);
      wr(8'h01, 8'h00);
      $display("compare done");
      wr(8'h00, 8'h20);
      repeat (40) @(posedge ref_clk_i);
      chk(pwr_o, 1'b1);
      wr(8'h00, 8'h1f);
      repeat (20) @(posedge ref_clk_i);
      chk(pwr_o, 1'b0);
      rd(8'h01, 8'h00);
      wr(8'h06, 8'h06);
      wr(8'h00, 8'h40);
      wait_irq(60, 1'b0);
      for (int s = 1; s < 4; s += 2) begin
         wr(8'h06, 8'(4 + s));
         wr(8'h00, 8'h40);
         wait_irq(200, 1'b1);
         rd(8'h03, target[7:0]);
      end
      $display("clocks and stop done");
      pwr_i <= ADCCTL_PWR_STOP3;
      wr(8'h06, 8'h04);
      wr(8'h00, 8'h40);
      wait_irq(60, 1'b0);
      wr(8'h09, 8'h07);
      repeat (2) @(posedge ref_clk_i);
      chk(bg, 1'b1);
      wr(8'h00, 8'h40);
      wait_irq(60, 1'b1);
      $display("stop mode done");
      pwr_i <= ADCCTL_PWR_WAIT;
      wr(8'h01, 8'h40);
      wr(8'h00, 8'h40);
      wr(8'h08, 8'h01);
      wait_irq(400, 1'b1);
      rd(8'h03, target[7:0]);
      repeat (60) @(posedge ref_clk_i);
      chk(irq, 1'b0);
      wait_irq(200, 1'b1);
      wr(8'h08, 8'h11);
      rd(8'h03, target[7:0]);
      wait_irq(100, 1'b1);
      $display("hardware trigger done");
      end_sim();
   end
endmodule : adcctl_top_tb

`default_nettype wire
